/* File: rtl/jcu_pkg.sv */
// package: register map, field layout and link constants for the character uart
//
// Functional notes
// - software sees exactly two 32-bit registers
// - char data register at lower address, control at the next word
// - receive fifo buffers up to 64 characters from the host
// - rx_fill_count sits in data register bits 31..16
// - host character arriving at a full receive fifo is discarded
// - non-empty receive fifo gives rx_char_valid bit 15 set, count one below the fill
// - data read returns head char, pops it, count already decremented
// - empty receive fifo read returns rx_char_valid 0, low byte undefined
// - transmit fifo holds 64 characters for the host
// - data register write pushes low byte into the transmit fifo
// - data register write leaves receive fifo and count alone
// - tx_free_space sits in control register bits 31..16
// - write into full transmit fifo is dropped
// - host_access_flag bit 10 sets on host access and stays set
// - writing 1 to host_access_flag clears it
// - rx_irq_enable and tx_irq_enable gate the two interrupts
// - interrupt while enabled and fill or free space above 7
// - pending receive and transmit interrupts shown in control register
// - pending clears once the threshold condition no longer holds
package jcu_pkg;
  localparam logic [31:0] ADDR_CHAR_DATA = 32'hff20_1000;
  localparam logic [31:0] ADDR_CONTROL = 32'hff20_1004;
  localparam int FIFO_DEPTH = 64;
  localparam int IRQ_THRESHOLD = 7;
  // field positions
  localparam int COUNT_LSB = 16;
  localparam int VALID_BIT = 15;
  localparam int ACCESS_BIT = 10;
  localparam int TX_PEND_BIT = 9;
  localparam int RX_PEND_BIT = 8;
  localparam int TX_EN_BIT = 1;
  localparam int RX_EN_BIT = 0;
  // reset values
  localparam logic RESET_IRQ_EN = 1'b0;
  localparam logic RESET_ACCESS = 1'b0;
  // link frame: one flag bit then eight character bits
  localparam int FRAME_BITS = 9;
endpackage

/* File: rtl/jcu_top.sv */
// character uart: apb registers, two fifos and the serial host link
`timescale 1ns/1ps
`default_nettype none
module jcu_top #(
  parameter int DEPTH = jcu_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic link_clk_i,
  input wire logic link_sel_i,
  input wire logic link_din_i,
  output logic link_dout_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] THRESH = CW'(jcu_pkg::IRQ_THRESHOLD);
  localparam logic [3:0] NBITS = 4'(jcu_pkg::FRAME_BITS);

  // fifo storage
  logic [7:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] rx_rd;
  logic [AW-1:0] rx_wr;
  logic [CW-1:0] rx_cnt;
  logic [AW-1:0] tx_rd;
  logic [AW-1:0] tx_wr;
  logic [CW-1:0] tx_cnt;

  // register state
  logic rx_irq_enable;
  logic tx_irq_enable;
  logic host_access_flag;
  logic rx_irq_pending;
  logic tx_irq_pending;

  // link synchronisers and frame state
  logic [1:0] clk_sync;
  logic [1:0] sel_sync;
  logic [1:0] din_sync;
  logic clk_prev;
  logic sel_prev;
  logic [8:0] rx_shift;
  logic [8:0] tx_shift;
  logic [3:0] bit_cnt;
  logic tx_offered;

  // bus decode
  logic acc_done;
  logic hit_data;
  logic hit_ctrl;
  logic rd_pop;
  logic wr_push;
  logic wr_ctrl;
  logic link_rise;
  logic link_fall;
  logic frame_start;
  logic frame_end;
  logic frame_ok;
  logic lk_push;
  logic lk_pop;
  logic rx_empty;

  assign acc_done = psel_i && penable_i && pready_o;
  assign hit_data = (paddr_i == jcu_pkg::ADDR_CHAR_DATA);
  assign hit_ctrl = (paddr_i == jcu_pkg::ADDR_CONTROL);
  assign rx_empty = (rx_cnt == '0);
  assign rd_pop = acc_done && !pwrite_i && hit_data && !rx_empty;
  assign wr_push = acc_done && pwrite_i && hit_data && (tx_cnt != FULL);
  assign wr_ctrl = acc_done && pwrite_i && hit_ctrl;

  // edges of the synchronised link clock and select
  assign link_rise = clk_sync[1] && !clk_prev;
  assign link_fall = !clk_sync[1] && clk_prev;
  assign frame_start = sel_sync[1] && !sel_prev;
  assign frame_end = !sel_sync[1] && sel_prev;
  assign frame_ok = frame_end && (bit_cnt == NBITS);
  assign lk_push = frame_ok && rx_shift[0] && (rx_cnt != FULL);
  assign lk_pop = frame_ok && tx_offered;

  // two-flop synchronisers for every link input pin
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      clk_sync <= '0;
      sel_sync <= '0;
      din_sync <= '0;
      clk_prev <= 1'b0;
      sel_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], link_clk_i};
      sel_sync <= {sel_sync[0], link_sel_i};
      din_sync <= {din_sync[0], link_din_i};
      clk_prev <= clk_sync[1];
      sel_prev <= sel_sync[1];
    end
  end

  // link frame shifting: sample on rise, drive on fall
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_shift <= '0;
      tx_shift <= '0;
      bit_cnt <= '0;
      tx_offered <= 1'b0;
    end
    else if (frame_start)
    begin
      bit_cnt <= '0;
      rx_shift <= '0;
      tx_offered <= (tx_cnt != '0);
      tx_shift <= {tx_mem[tx_rd], (tx_cnt != '0)};
    end
    else if (sel_sync[1])
    begin
      if (link_rise && bit_cnt != NBITS)
      begin
        rx_shift <= {din_sync[1], rx_shift[8:1]};
        bit_cnt <= bit_cnt + 4'd1;
      end
      if (link_fall)
      begin
        tx_shift <= {1'b0, tx_shift[8:1]};
      end
    end
  end

  // serial output from its own flop
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      link_dout_o <= 1'b0;
    end
    else if (frame_start)
    begin
      link_dout_o <= (tx_cnt != '0);
    end
    else if (sel_sync[1] && link_fall)
    begin
      link_dout_o <= tx_shift[1];
    end
  end

  // receive fifo: host pushes, software pops
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_rd <= '0;
      rx_wr <= '0;
      rx_cnt <= '0;
    end
    else
    begin
      if (lk_push)
      begin
        rx_mem[rx_wr] <= rx_shift[8:1];
        rx_wr <= rx_wr + 1'b1;
      end
      if (rd_pop)
      begin
        rx_rd <= rx_rd + 1'b1;
      end
      if (lk_push && !rd_pop) // data writes never touch this fifo
      begin
        rx_cnt <= rx_cnt + 1'b1;
      end
      else if (rd_pop && !lk_push)
      begin
        rx_cnt <= rx_cnt - 1'b1;
      end
    end
  end

  // transmit fifo: software pushes, host drains
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_rd <= '0;
      tx_wr <= '0;
      tx_cnt <= '0;
    end
    else
    begin
      if (wr_push)
      begin
        tx_mem[tx_wr] <= pwdata_i[7:0];
        tx_wr <= tx_wr + 1'b1;
      end
      if (lk_pop)
      begin
        tx_rd <= tx_rd + 1'b1;
      end
      if (wr_push && !lk_pop)
      begin
        tx_cnt <= tx_cnt + 1'b1;
      end
      else if (lk_pop && !wr_push)
      begin
        tx_cnt <= tx_cnt - 1'b1;
      end
    end
  end

  // interrupt enables
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_irq_enable <= jcu_pkg::RESET_IRQ_EN;
      tx_irq_enable <= jcu_pkg::RESET_IRQ_EN;
    end
    else if (wr_ctrl)
    begin
      rx_irq_enable <= pwdata_i[jcu_pkg::RX_EN_BIT];
      tx_irq_enable <= pwdata_i[jcu_pkg::TX_EN_BIT];
    end
  end

  // host access flag: a new frame wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      host_access_flag <= jcu_pkg::RESET_ACCESS;
    end
    else if (frame_start)
    begin
      host_access_flag <= 1'b1;
    end
    else if (wr_ctrl && pwdata_i[jcu_pkg::ACCESS_BIT])
    begin
      host_access_flag <= 1'b0;
    end
  end

  // level interrupts follow the thresholds
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_irq_pending <= 1'b0;
      tx_irq_pending <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      rx_irq_pending <= rx_irq_enable && (rx_cnt > THRESH);
      tx_irq_pending <= tx_irq_enable && ((FULL - tx_cnt) > THRESH);
      irq_o <= rx_irq_pending || tx_irq_pending;
    end
  end

  // apb slave: one wait state, answer built in the wait cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      pready_o <= 1'b1;
      pslverr_o <= !(hit_data || hit_ctrl);
      prdata_o <= '0;
      if (!pwrite_i && hit_data)
      begin
        prdata_o[31:jcu_pkg::COUNT_LSB] <= 16'(rx_empty ? rx_cnt : rx_cnt - 1'b1);
        prdata_o[jcu_pkg::VALID_BIT] <= !rx_empty;
        prdata_o[7:0] <= rx_mem[rx_rd];
      end
      else if (!pwrite_i && hit_ctrl)
      begin
        prdata_o[31:jcu_pkg::COUNT_LSB] <= 16'(FULL - tx_cnt);
        prdata_o[jcu_pkg::ACCESS_BIT] <= host_access_flag;
        prdata_o[jcu_pkg::TX_PEND_BIT] <= tx_irq_pending;
        prdata_o[jcu_pkg::RX_PEND_BIT] <= rx_irq_pending;
        prdata_o[jcu_pkg::TX_EN_BIT] <= tx_irq_enable;
        prdata_o[jcu_pkg::RX_EN_BIT] <= rx_irq_enable;
      end
    end
    else
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end
endmodule // jcu_top
`default_nettype wire

/* File: verification/jcu_top_assertions.sv */
// checker on the uart top ports
`timescale 1ns/1ps
`default_nettype none
module jcu_top_assertions #(
  parameter int DEPTH = 64
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic irq_o
);
  logic acc;
  logic hit;
  logic rdd;
  logic en_seen;
  // first access cycle, mapped address, data read answer
  assign acc = psel_i && penable_i && !pready_o;
  assign hit = paddr_i == jcu_pkg::ADDR_CHAR_DATA || paddr_i == jcu_pkg::ADDR_CONTROL;
  assign rdd = pready_o && !pwrite_i && paddr_i == jcu_pkg::ADDR_CHAR_DATA;
  // set once software writes an enable
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      en_seen <= 1'b0;
    else if (pready_o && pwrite_i && paddr_i == jcu_pkg::ADDR_CONTROL && |pwdata_i[1:0])
      en_seen <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  a_ready_wait: assert property (acc |=> pready_o)
    else $error("no answer after wait state");
  a_err_unmapped: assert property (acc && !hit |=> pslverr_o)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && hit |=> !pslverr_o)
    else $error("mapped access refused");
  a_empty_zero: assert property (rdd && !prdata_o[15] |-> prdata_o[31:16] == 16'h0000)
    else $error("empty read with count");
  a_count_bound: assert property (rdd |-> prdata_o[31:16] < DEPTH)
    else $error("fill count too large");
  a_irq_gate: assert property (irq_o |-> en_seen)
    else $error("irq without enable");
  a_reset_quiet: assert property (disable iff (1'b0) $fell(reset_i) |-> !pready_o && !irq_o)
    else $error("outputs busy after reset");
  c_err: cover property (pslverr_o);
  c_irq: cover property (irq_o);
  c_valid: cover property (rdd && prdata_o[15]);
endmodule // jcu_top_assertions
`default_nettype wire

/* File: verification/jcu_host_model.sv */
// host side of the serial link, frame by frame
`timescale 1ns/1ps
`default_nettype none
module jcu_host_model (
  output logic link_clk_o,
  output logic link_sel_o,
  output logic link_din_o,
  input wire logic link_dout_i
);
  // idle link: clock stands still, select low
  initial
  begin
    link_clk_o = 1'b0;
    link_sel_o = 1'b0;
    link_din_o = 1'b0;
  end
  // one frame: flag and char out, offer flag and char back
  task automatic frame(input logic has, input logic [7:0] ch, output logic [8:0] got);
    logic [8:0] tx;
    tx = {ch, has};
    #7;
    link_sel_o = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      link_din_o = tx[i];
      #100;
      link_clk_o = 1'b1;
      got[i] = link_dout_i;
      #100;
      link_clk_o = 1'b0;
    end
    link_sel_o = 1'b0;
    link_din_o = ~link_din_o; // last data bit inverted once released
    #400;
  endtask
endmodule // jcu_host_model
`default_nettype wire

/* File: verification/jtag_character_uart_tb_top.sv */
// testbench for the character uart
`timescale 1ns/1ps
`default_nettype none
module jtag_character_uart_tb_top;
  localparam int D = 64;
  localparam logic [31:0] DA = jcu_pkg::ADDR_CHAR_DATA;
  localparam logic [31:0] CA = jcu_pkg::ADDR_CONTROL;
  localparam logic [31:0] M = 32'hffff_80ff;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] padr = 32'h0000_0000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic rdy, err, irq, lclk, lsel, ldin, ldout;
  logic [31:0] r;
  logic e;
  logic [8:0] g;
  int err_total = 0;
  int samples_checked = 0;
  // design and host
  jcu_top #(.DEPTH(D)) uut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(err), .irq_o(irq), .link_clk_i(lclk),
    .link_sel_i(lsel), .link_din_i(ldin), .link_dout_o(ldout));
  jcu_host_model host (.link_clk_o(lclk), .link_sel_o(lsel), .link_din_o(ldin),
    .link_dout_i(ldout));
  // system clock
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    r = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20)
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      tally_and_finish();
    end
  endtask
  task automatic t_idle();
    apb(1'b0, CA, 32'h0000_0000);
    chk(r, {16'(D), 16'h0000});
    apb(1'b0, DA, 32'h0000_0000);
    chk(r & 32'hffff_8000, 32'h0000_0000);
    apb(1'b0, CA + 32'h0000_0008, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    $display("t_idle done");
  endtask
  task automatic t_rx();
    host.frame(1'b1, 8'h5a, g);
    host.frame(1'b1, 8'ha5, g);
    apb(1'b1, DA, 32'h0000_0033);
    host.frame(1'b0, 8'h00, g);
    chk({23'h0, g}, {23'h0, 8'h33, 1'b1});
    apb(1'b0, CA, 32'h0000_0000);
    chk(r & 32'h0000_0400, 32'h0000_0400);
    apb(1'b1, CA, 32'h0000_0400);
    apb(1'b0, CA, 32'h0000_0000);
    chk(r & 32'h0000_0400, 32'h0000_0000);
    apb(1'b0, DA, 32'h0000_0000);
    chk(r & M, 32'h0001_805a);
    apb(1'b0, DA, 32'h0000_0000);
    chk(r & M, 32'h0000_80a5);
    $display("t_rx done");
  endtask
  task automatic t_rx_full();
    apb(1'b1, CA, 32'h0000_0001);
    for (int i = 0; i <= D; i++)
      host.frame(1'b1, 8'(i), g);
    apb(1'b0, CA, 32'h0000_0000);
    chk(r & 32'h0000_0101, 32'h0000_0101);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, CA, 32'h0000_0000);
    apb(1'b0, CA, 32'h0000_0000);
    chk(r & 32'h0000_0101, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, CA, 32'h0000_0001);
    for (int i = 0; i < D; i++)
    begin
      apb(1'b0, DA, 32'h0000_0000);
      chk(r & M, {16'(D - 1 - i), 8'h80, 8'(i)});
    end
    apb(1'b0, CA, 32'h0000_0000);
    chk(r & 32'h0000_0100, 32'h0000_0000);
    $display("t_rx_full done");
  endtask
  task automatic t_tx();
    apb(1'b1, CA, 32'h0000_0002);
    apb(1'b0, CA, 32'h0000_0000);
    chk(r & 32'hffff_0203, {16'(D), 16'h0202});
    for (int i = 0; i <= D; i++)
      apb(1'b1, DA, 32'hab00 | 32'(i));
    apb(1'b0, CA, 32'h0000_0000);
    chk(r & 32'hffff_0200, 32'h0000_0000);
    for (int i = 0; i < D; i++)
    begin
      host.frame(1'b0, 8'h00, g);
      chk({23'h0, g}, {23'h0, 8'(i), 1'b1});
    end
    host.frame(1'b0, 8'h00, g);
    chk({31'h0, g[0]}, 32'h0000_0000);
    $display("t_tx done");
  endtask
  // reset, then the scenarios
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_idle();
    t_rx();
    t_rx_full();
    t_tx();
    tally_and_finish();
  end
endmodule // jtag_character_uart_tb_top
bind jcu_top jcu_top_assertions #(.DEPTH(DEPTH)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .irq_o(irq_o));
`default_nettype wire
